// >>> bsc_defines.svh
// Constants of the background scan control page: layout, resets, timing.
// Assumes inclusion by bare name from the package only.
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH
// Page identity and fixed bytes
`define BSC_PAGE_CODE        6'h1C
`define BSC_SUBPAGE_CODE     8'h01
`define BSC_PAGE_LENGTH      16'h000C
// Byte offsets within the page
`define BSC_OFF_HDR          4'h0
`define BSC_OFF_SUBPAGE      4'h1
`define BSC_OFF_LEN_HI       4'h2
`define BSC_OFF_LEN_LO       4'h3
`define BSC_OFF_SCAN_FLAGS   4'h4
`define BSC_OFF_PRE_FLAGS    4'h5
`define BSC_OFF_INTV_HI      4'h6
`define BSC_OFF_INTV_LO      4'h7
`define BSC_OFF_LIMIT_HI     4'h8
`define BSC_OFF_LIMIT_LO     4'h9
`define BSC_OFF_IDLE_HI      4'hA
`define BSC_OFF_IDLE_LO      4'hB
`define BSC_OFF_SUSP_HI      4'hC
`define BSC_OFF_SUSP_LO      4'hD
// Field positions
`define BSC_BIT_SCAN_EN      0
`define BSC_BIT_LOG_UNREC    1
`define BSC_BIT_SUSP_FULL    2
`define BSC_BIT_PRE_EN       0
// Reset values and interval maximum
`define BSC_RST_FLAGS        3'h0
`define BSC_RST_INTERVAL     16'h03F0
`define BSC_RST_LIMIT        16'h0000
`define BSC_RST_IDLE_MS      16'h0000
`define BSC_RST_SUSP         16'h0000
`define BSC_MAX_INTERVAL     16'hE904
// Timing: clock rate, tick, idle floor and default
`define BSC_CLK_HZ           40000000
`define BSC_TICK_MS          50
`define BSC_HOUR_MS          3600000
`define BSC_IDLE_MIN_MS      17'h00064
`define BSC_IDLE_ZERO_MS     17'h003E8
`endif

// >>> bsc_engine_model.sv
// Scan engine and nonvolatile pre-scan store beside the scan controller.
// Assumes bench requests for done are levels set between clock edges.
`timescale 1ns/1ps
module bsc_engine_model
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Run levels and pre-scan bits to store from the controller, requests from the bench
  input  wire logic scan_run,
  input  wire logic prescan_run,
  input  wire logic end_scan,
  input  wire logic end_pre,
  input  wire logic en_out,
  input  wire logic armed_out,
  // Engine reports and stored bits to the controller
  output logic      scan_step,
  output logic      scan_done,
  output logic      prescan_done,
  output logic      nv_en,
  output logic      nv_armed
);
  logic [1:0] por_q;

  // Step on alternate cycles; done only while the run is granted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_step    <= 1'b0;
      scan_done    <= 1'b0;
      prescan_done <= 1'b0;
      por_q        <= 2'h0;
    end else begin
      scan_step    <= scan_run & ~scan_step;
      scan_done    <= scan_run & end_scan;
      prescan_done <= prescan_run & end_pre;
      por_q        <= {por_q[0], 1'b1};
    end
  end

  // Store survives rstn; it waits for capture so reset zeros are not saved
  initial begin
    nv_en    = 1'b0;
    nv_armed = 1'b0;
  end
  always @(posedge clk) begin
    if (rstn && por_q[1]) begin
      nv_en    <= en_out;
      nv_armed <= armed_out;
    end
  end
endmodule

// >>> bsc_pkg.sv
// Types shared by the background scan control modules.
// Assumes bsc_defines.svh is on the include path.
package bsc_pkg;
  `include "bsc_defines.svh"

  // Byte-wide page access from the command interpreter
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bsc_cfg_req_type;

  // Scan engine state, one-hot
  typedef enum logic [2:0] {
    BSC_ST_IDLE    = 3'h1,
    BSC_ST_PRESCAN = 3'h2,
    BSC_ST_SCAN    = 3'h4
  } bsc_state_type;
endpackage

// >>> bsc_sat_counter.sv
// Saturating up counter with synchronous clear; clear beats count.
// Assumes inc and clr are one-cycle pulses of the same clock.
`timescale 1ns/1ps
module bsc_sat_counter
  import bsc_pkg::*;
#(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         clr,
  input  wire logic         inc,
  // Count
  output logic [W-1:0]      cnt
);
  logic [W-1:0] cnt_q, cnt_d;

  // Saturate so a long quiet period never wraps back to zero
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = '0;
    end else if (inc && (cnt_q != {W{1'b1}})) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt = cnt_q;
endmodule

// >>> bsc_scan_ctrl.sv
// Background medium scan and pre-scan control page with its scheduler.
// Assumes rstn marks a power-on cycle, host inputs are synchronous to clk,
// and the nonvolatile pre-scan bits are valid at the first edge after reset.
`timescale 1ns/1ps
// Notes on behaviour
// - Page reads 1Ch, subpage 01h, length 0Ch
// - Suspend scans on full log when set
// - Log only unrecovered errors when set
// - Medium scan enable gates scanning
// - Disabling suspends scan, position kept, resumes later
// - Clearing pre-scan enable halts pre-scan
// - Pre-scan starts only after next power-on
// - Re-run needs enable zero, one, power-on
// - Interval hours between scan starts
// - Interval clamped at E904h hours
// - Pre-scan halted at hour limit, zero unlimited
// - Wait idle time first; zero means one second
// - Nonzero idle below 100 ms becomes 100
// - Idle timer steps in 50 ms ticks
// - Max suspend field stored, never used
module bsc_scan_ctrl
  import bsc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BSC_CLK_HZ / 1000 * `BSC_TICK_MS,
  parameter int unsigned HOUR_TICKS  = `BSC_HOUR_MS / `BSC_TICK_MS,
  parameter int unsigned POS_W       = 32,
  parameter logic        SAVABLE     = 1'b1
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // Page access
  input  wire bsc_cfg_req_type cfg_req,
  output logic [7:0]           cfg_rdata,
  output logic                 cfg_rvalid,
  // Host activity
  input  wire logic            host_cmd,
  // Scan engine
  input  wire logic            scan_step,
  input  wire logic            scan_done,
  input  wire logic            prescan_done,
  input  wire logic            log_full,
  output logic                 scan_run,
  output logic                 prescan_run,
  output logic [POS_W-1:0]     scan_pos,
  // Medium error reports
  input  wire logic            err_valid,
  input  wire logic            err_unrecovered,
  output logic                 log_write,
  // Nonvolatile pre-scan state
  input  wire logic            nv_prescan_en,
  input  wire logic            nv_prescan_armed,
  output logic                 nv_prescan_en_out,
  output logic                 nv_prescan_armed_out
);
  // Page fields
  logic [2:0]  flags_q, flags_d;
  logic        pre_en_q, pre_en_d;
  logic [15:0] intv_q, intv_d, limit_q, limit_d;
  logic [15:0] idle_ms_q, idle_ms_d, susp_q, susp_d;
  // Sequencing
  logic        por_q, armed_q, armed_d, pend_q, pend_d, once_q, once_d;
  bsc_state_type st_q, st_d;
  logic        scan_run_q, scan_run_d, pre_run_q, pre_run_d;
  logic [POS_W-1:0] pos_q, pos_d;
  logic        log_q, log_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q;
  // Timers
  logic        tick, hour;
  logic [15:0] idle_cnt, since_hrs, pre_hrs;
  logic        scan_start, pre_start;
  logic        medium_scan_enable, log_unrec, susp_full, susp_now, idle_ok;
  logic [15:0] intv_eff, idle_thr;
  logic [16:0] idle_eff;
  logic        pre_timeout, pre_end;

  assign medium_scan_enable    = flags_q[`BSC_BIT_SCAN_EN];
  assign log_unrec = flags_q[`BSC_BIT_LOG_UNREC];
  assign susp_full = flags_q[`BSC_BIT_SUSP_FULL];
  assign susp_now  = susp_full & log_full;

  // The 50 ms tick feeds both the idle timer and the hour count
  bsc_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .en   (1'b1),
    .tick (tick)
  );
  bsc_tick_div #(.DIV(HOUR_TICKS)) u_hour (
    .clk  (clk),
    .rstn (rstn),
    .en   (tick),
    .tick (hour)
  );
  // Idle restarts on every host command
  bsc_sat_counter #(.W(16)) u_idle (
    .clk  (clk),
    .rstn (rstn),
    .clr  (host_cmd),
    .inc  (tick),
    .cnt  (idle_cnt)
  );
  // Hours since last scan start
  bsc_sat_counter #(.W(16)) u_since (
    .clk  (clk),
    .rstn (rstn),
    .clr  (scan_start),
    .inc  (hour),
    .cnt  (since_hrs)
  );
  // Hours spent in the current pre-scan
  bsc_sat_counter #(.W(16)) u_pre_hrs (
    .clk  (clk),
    .rstn (rstn),
    .clr  (pre_start),
    .inc  (hour & (st_q == BSC_ST_PRESCAN)),
    .cnt  (pre_hrs)
  );

  // Effective interval and idle threshold, rounded up to whole ticks
  always_comb begin
    intv_eff = (intv_q > `BSC_MAX_INTERVAL) ? `BSC_MAX_INTERVAL
                                            : intv_q;
    if (idle_ms_q == 16'h0000) begin
      idle_eff = `BSC_IDLE_ZERO_MS;
    end else if ({1'b0, idle_ms_q} < `BSC_IDLE_MIN_MS) begin
      idle_eff = `BSC_IDLE_MIN_MS;
    end else begin
      idle_eff = {1'b0, idle_ms_q};
    end
    idle_thr = 16'((idle_eff + 17'(`BSC_TICK_MS - 1)) / 17'(`BSC_TICK_MS));
  end
  assign idle_ok = (idle_cnt >= idle_thr) & ~host_cmd;

  assign pre_timeout = (limit_q != 16'h0000) & (pre_hrs >= limit_q);

  // Page writes; the maximum suspend field is kept but drives nothing
  always_comb begin
    flags_d   = flags_q;
    pre_en_d  = pre_en_q;
    intv_d    = intv_q;
    limit_d   = limit_q;
    idle_ms_d = idle_ms_q;
    susp_d    = susp_q;
    if (!por_q) begin
      pre_en_d = nv_prescan_en;
    end else if (cfg_req.wr) begin
      unique case (cfg_req.addr)
        `BSC_OFF_SCAN_FLAGS: flags_d       = cfg_req.wdata[2:0];
        `BSC_OFF_PRE_FLAGS:  pre_en_d      = cfg_req.wdata[`BSC_BIT_PRE_EN];
        `BSC_OFF_INTV_HI:    intv_d[15:8]  = cfg_req.wdata;
        `BSC_OFF_INTV_LO:    intv_d[7:0]   = cfg_req.wdata;
        `BSC_OFF_LIMIT_HI:   limit_d[15:8] = cfg_req.wdata;
        `BSC_OFF_LIMIT_LO:   limit_d[7:0]  = cfg_req.wdata;
        `BSC_OFF_IDLE_HI:    idle_ms_d[15:8] = cfg_req.wdata;
        `BSC_OFF_IDLE_LO:    idle_ms_d[7:0]  = cfg_req.wdata;
        `BSC_OFF_SUSP_HI:    susp_d[15:8]  = cfg_req.wdata;
        `BSC_OFF_SUSP_LO:    susp_d[7:0]   = cfg_req.wdata;
        default: ;
      endcase
    end
  end

  // Page reads, big-endian fields, reserved bytes read zero
  always_comb begin
    rdata_d = rdata_q;
    if (cfg_req.rd) begin
      unique case (cfg_req.addr)
        `BSC_OFF_HDR:        rdata_d = {SAVABLE, 1'b1, `BSC_PAGE_CODE};
        `BSC_OFF_SUBPAGE:    rdata_d = `BSC_SUBPAGE_CODE;
        `BSC_OFF_LEN_HI:     rdata_d = 8'(`BSC_PAGE_LENGTH >> 8);
        `BSC_OFF_LEN_LO:     rdata_d = 8'(`BSC_PAGE_LENGTH);
        `BSC_OFF_SCAN_FLAGS: rdata_d = {5'h00, flags_q};
        `BSC_OFF_PRE_FLAGS:  rdata_d = {7'h00, pre_en_q};
        `BSC_OFF_INTV_HI:    rdata_d = intv_q[15:8];
        `BSC_OFF_INTV_LO:    rdata_d = intv_q[7:0];
        `BSC_OFF_LIMIT_HI:   rdata_d = limit_q[15:8];
        `BSC_OFF_LIMIT_LO:   rdata_d = limit_q[7:0];
        `BSC_OFF_IDLE_HI:    rdata_d = idle_ms_q[15:8];
        `BSC_OFF_IDLE_LO:    rdata_d = idle_ms_q[7:0];
        `BSC_OFF_SUSP_HI:    rdata_d = susp_q[15:8];
        `BSC_OFF_SUSP_LO:    rdata_d = susp_q[7:0];
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  // Scheduler: which scan is in progress and whether it may run now
  always_comb begin
    st_d       = st_q;
    pend_d     = pend_q;
    once_d     = once_q;
    scan_start = 1'b0;
    pre_start  = 1'b0;
    pre_end    = 1'b0;
    if (!por_q) begin
      pend_d = nv_prescan_en & nv_prescan_armed;
    end
    unique case (st_q)
      BSC_ST_IDLE: begin
        if (pend_q && pre_en_q && idle_ok) begin
          st_d      = BSC_ST_PRESCAN;
          pre_start = 1'b1;
        end else if (medium_scan_enable && idle_ok && !susp_now &&
                     (!once_q || since_hrs >= intv_eff)) begin
          st_d       = BSC_ST_SCAN;
          scan_start = 1'b1;
          once_d     = 1'b1;
        end
      end
      BSC_ST_PRESCAN: begin
        // Halt on disable or time limit, finish on done
        if (!pre_en_q || pre_timeout || (prescan_done && pre_run_q)) begin
          st_d    = BSC_ST_IDLE;
          pre_end = 1'b1;
          pend_d  = 1'b0;
        end
      end
      BSC_ST_SCAN: begin
        // A disabled scan stays here, suspended in place
        if (scan_done && scan_run_q) begin
          st_d = BSC_ST_IDLE;
        end
      end
      default: st_d = BSC_ST_IDLE;
    endcase
    scan_run_d = (st_d == BSC_ST_SCAN) & medium_scan_enable & idle_ok
               & ~susp_now;
    pre_run_d  = (st_d == BSC_ST_PRESCAN) & pre_en_q & idle_ok
               & ~susp_now;
  end

  // Arming: loaded at power-on, set by a zero-to-one write, which beats a pre-scan end in the same cycle
  always_comb begin
    armed_d = armed_q;
    if (!por_q) begin
      armed_d = nv_prescan_armed;
    end else if (cfg_req.wr && cfg_req.addr == `BSC_OFF_PRE_FLAGS &&
                 cfg_req.wdata[`BSC_BIT_PRE_EN] && !pre_en_q) begin
      armed_d = 1'b1;
    end else if (pre_end) begin
      armed_d = 1'b0;
    end
  end

  // Position survives suspension, restarts only with a new scan
  always_comb begin
    pos_d = pos_q;
    if (scan_start) begin
      pos_d = '0;
    end else if (scan_step && scan_run_q) begin
      pos_d = pos_q + POS_W'(1);
    end
    log_d = err_valid & (~log_unrec | err_unrecovered);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_q      <= 1'b0;
      flags_q    <= `BSC_RST_FLAGS;
      pre_en_q   <= 1'b0;
      intv_q     <= `BSC_RST_INTERVAL;
      limit_q    <= `BSC_RST_LIMIT;
      idle_ms_q  <= `BSC_RST_IDLE_MS;
      susp_q     <= `BSC_RST_SUSP;
      armed_q    <= 1'b0;
      pend_q     <= 1'b0;
      once_q     <= 1'b0;
      st_q       <= BSC_ST_IDLE;
      scan_run_q <= 1'b0;
      pre_run_q  <= 1'b0;
      pos_q      <= '0;
      log_q      <= 1'b0;
      rdata_q    <= 8'h00;
      rvalid_q   <= 1'b0;
    end else begin
      por_q      <= 1'b1;
      flags_q    <= flags_d;
      pre_en_q   <= pre_en_d;
      intv_q     <= intv_d;
      limit_q    <= limit_d;
      idle_ms_q  <= idle_ms_d;
      susp_q     <= susp_d;
      armed_q    <= armed_d;
      pend_q     <= pend_d;
      once_q     <= once_d;
      st_q       <= st_d;
      scan_run_q <= scan_run_d;
      pre_run_q  <= pre_run_d;
      pos_q      <= pos_d;
      log_q      <= log_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= cfg_req.rd;
    end
  end

  assign cfg_rdata            = rdata_q;
  assign cfg_rvalid           = rvalid_q;
  assign scan_run             = scan_run_q;
  assign prescan_run          = pre_run_q;
  assign scan_pos             = pos_q;
  assign log_write            = log_q;
  assign nv_prescan_en_out    = pre_en_q;
  assign nv_prescan_armed_out = armed_q;

  // Checks on the page and the scheduler
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  page_code_a: assert property (cfg_req.rd && cfg_req.addr == `BSC_OFF_HDR
    |=> cfg_rdata == {SAVABLE, 1'b1, `BSC_PAGE_CODE} && cfg_rvalid)
    else $error("page header byte wrong");
  full_suspend_a: assert property (susp_full && log_full
    |=> !scan_run && !prescan_run)
    else $error("scan ran with log full");
  log_filter_a: assert property (err_valid && log_unrec && !err_unrecovered
    |=> !log_write)
    else $error("recovered error logged");
  scan_gate_a: assert property (!medium_scan_enable |=> !scan_run)
    else $error("scan ran while disabled");
  scan_hold_a: assert property (st_q == BSC_ST_SCAN && !scan_run_q
    && !scan_start |=> pos_q == $past(pos_q))
    else $error("position moved while suspended");
  prescan_halt_a: assert property (por_q && st_q == BSC_ST_PRESCAN
    && !pre_en_q |=> st_q == BSC_ST_IDLE && !prescan_run)
    else $error("pre-scan not halted");
  prescan_defer_a: assert property (pre_start |-> pend_q)
    else $error("pre-scan started unarmed");
  rearm_a: assert property (st_q == BSC_ST_PRESCAN ##1 st_q == BSC_ST_IDLE
    |-> !pend_q [*2])
    else $error("pre-scan pending after end");
  interval_a: assert property (scan_start && once_q
    |-> since_hrs >= intv_eff)
    else $error("scan started early");
  clamp_a: assert property (intv_q > `BSC_MAX_INTERVAL
    |-> intv_eff == `BSC_MAX_INTERVAL)
    else $error("interval not clamped");
  time_limit_a: assert property (st_q == BSC_ST_PRESCAN && limit_q != 0
    && pre_hrs >= limit_q |=> st_q == BSC_ST_IDLE)
    else $error("pre-scan overran limit");
  idle_zero_a: assert property (idle_ms_q == 16'h0000
    |-> idle_thr == 16'h0014)
    else $error("zero idle not one second");
  idle_floor_a: assert property (idle_ms_q != 16'h0000
    && idle_ms_q < 16'h0064 |-> idle_thr == 16'h0002)
    else $error("idle floor wrong");
  cmd_pause_a: assert property (host_cmd
    |=> !scan_run && !prescan_run && idle_cnt == 16'h0000)
    else $error("command did not pause scan");

  scan_runs_c: cover property (scan_start ##[1:20] scan_run);
  prescan_ends_c: cover property (pre_start ##[1:50] pre_end);
  scan_resume_c: cover property (scan_run ##1 !scan_run ##[1:50] scan_run);
endmodule

// >>> bsc_tick_div.sv
// Enable divider: one-cycle tick every DIV enabled cycles.
// Assumes en is a one-cycle enable from the same clock.
`timescale 1ns/1ps
module bsc_tick_div
  import bsc_pkg::*;
#(
  parameter int unsigned DIV = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Enable in, tick out
  input  wire logic en,
  output logic      tick
);
  localparam int unsigned W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic         tick_q, tick_d;

  // Wrap the count and pulse on the last enabled cycle
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (en) begin
      if (cnt_q == LAST) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

// >>> tb_top.sv
// Self-checking bench of the scan control page and scheduler.
// Assumes short tick and hour parameters; rstn stands for power-on.
`timescale 1ns/1ps
module tb_top
  import bsc_pkg::*;
;
  localparam int TK = 4;
  localparam int HR = 12;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  bsc_cfg_req_type req;
  logic [7:0]      rdata;
  logic [31:0]     scan_pos;
  logic            rvalid, host_cmd, log_full, err_valid, err_unrec;
  logic            log_write, scan_run, prescan_run, scan_step;
  logic            scan_done, prescan_done, nv_en, nv_armed;
  logic            en_out, armed_out, end_scan, end_pre;
  int              n_fail = 0;
  int              compares = 0;
  int              cyc = 0;
  int              n, t0;

  // Clock and cycle count
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  bsc_scan_ctrl #(.TICK_CYCLES(TK), .HOUR_TICKS(3)) uut (
    .clk(clk), .rstn(rstn), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .host_cmd(host_cmd), .scan_step(scan_step),
    .scan_done(scan_done), .prescan_done(prescan_done),
    .log_full(log_full), .scan_run(scan_run), .prescan_run(prescan_run),
    .scan_pos(scan_pos), .err_valid(err_valid),
    .err_unrecovered(err_unrec), .log_write(log_write),
    .nv_prescan_en(nv_en), .nv_prescan_armed(nv_armed),
    .nv_prescan_en_out(en_out), .nv_prescan_armed_out(armed_out));

  bsc_engine_model eng (
    .clk(clk), .rstn(rstn), .scan_run(scan_run),
    .prescan_run(prescan_run), .end_scan(end_scan), .end_pre(end_pre),
    .en_out(en_out), .armed_out(armed_out), .scan_step(scan_step),
    .scan_done(scan_done), .prescan_done(prescan_done), .nv_en(nv_en),
    .nv_armed(nv_armed));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Page write: one cycle strobe, no answer
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  // Page read: answer stands from the taken edge, checked half a cycle later
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    check("rvalid", rvalid, 1'b1);
    check($sformatf("byte %h", a), rdata, e);
    req = '0;
  endtask

  // Bounded wait for a run level, then compare it
  task automatic wait_run(bit pre, logic lvl, int max);
    n = 0;
    while (n < max && (pre ? prescan_run : scan_run) !== lvl) begin
      @(negedge clk);
      n++;
    end
    check(pre ? "prescan_run" : "scan_run", pre ? prescan_run : scan_run,
          lvl);
  endtask

  task automatic err_case(logic unrec, logic exp);
    @(negedge clk);
    err_valid = 1'b1;
    err_unrec = unrec;
    @(negedge clk);
    err_valid = 1'b0;
    check("log_write", log_write, exp);
  endtask

  // Host command pauses the scan; resume must wait the idle window
  task automatic idle_case(logic [15:0] ms, int ticks);
    wr(4'hA, ms[15:8]);
    wr(4'hB, ms[7:0]);
    @(negedge clk);
    host_cmd = 1'b1;
    @(negedge clk);
    host_cmd = 1'b0;
    @(negedge clk);
    check("paused", scan_run, 1'b0);
    wait_run(0, 1'b1, 400);
    check("idle_win", n + 2 >= (ticks - 1) * TK
          && n <= (ticks + 1) * TK + 2, 1'b1);
  endtask

  task automatic pwr_cycle();
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // Watchdog sized well above the expected run of about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  // Main sequence
  initial begin
    req = '0;
    host_cmd = 1'b0;
    log_full = 1'b0;
    err_valid = 1'b0;
    err_unrec = 1'b0;
    end_scan = 1'b0;
    end_pre = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], a == 0 ? 8'hDC : a == 1 ? 8'h01 : a == 3 ? 8'h0C :
         a == 6 ? 8'h03 : a == 7 ? 8'hF0 : 8'h00);
    end
    wr(4'h0, 8'h00);
    rd(4'h0, 8'hDC);
    wr(4'hE, 8'hFF);
    rd(4'hE, 8'h00);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h07);
    wr(4'h4, 8'h00);
    wr(4'hC, 8'h12);
    wr(4'hD, 8'h34);
    rd(4'hC, 8'h12);
    rd(4'hD, 8'h34);
    wr(4'h6, 8'hFF);
    wr(4'h7, 8'hFF);
    rd(4'h6, 8'hFF);
    $display("test page done");
    err_case(1'b0, 1'b1);
    err_case(1'b1, 1'b1);
    wr(4'h4, 8'h02);
    err_case(1'b0, 1'b0);
    err_case(1'b1, 1'b1);
    $display("test log done");
    wr(4'h4, 8'h01);
    idle_case(16'h0000, 20);
    idle_case(16'h0001, 2);
    idle_case(16'h003C, 2);
    idle_case(16'h0104, 6);
    $display("test idle done");
    repeat (6) @(negedge clk);
    wr(4'h4, 8'h00);
    repeat (2) @(negedge clk);
    check("scan_run", scan_run, 1'b0);
    t0 = scan_pos;
    repeat (20) @(negedge clk);
    check("pos_hold", scan_pos, t0);
    wr(4'h4, 8'h01);
    wait_run(0, 1'b1, 10);
    repeat (4) @(negedge clk);
    check("pos_go", scan_pos > t0 && scan_pos <= t0 + 3, 1'b1);
    log_full = 1'b1;
    repeat (6) @(negedge clk);
    check("scan_run", scan_run, 1'b1);
    wr(4'h4, 8'h05);
    repeat (2) @(negedge clk);
    check("scan_run", scan_run, 1'b0);
    log_full = 1'b0;
    wait_run(0, 1'b1, 10);
    $display("test suspend done");
    pwr_cycle();
    wr(4'hB, 8'h01);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h04);
    wr(4'h4, 8'h01);
    wait_run(0, 1'b1, 40);
    t0 = cyc;
    end_scan = 1'b1;
    wait_run(0, 1'b0, 10);
    end_scan = 1'b0;
    wait_run(0, 1'b1, 100);
    check("interval", cyc - t0 >= 3 * HR && cyc - t0 <= 5 * HR + 12,
          1'b1);
    $display("test interval done");
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h01);
    rd(4'h5, 8'h01);
    repeat (150) @(negedge clk);
    check("prescan_run", prescan_run, 1'b0);
    pwr_cycle();
    wait_run(1, 1'b1, 200);
    end_pre = 1'b1;
    wait_run(1, 1'b0, 10);
    end_pre = 1'b0;
    pwr_cycle();
    repeat (200) @(negedge clk);
    check("prescan_run", prescan_run, 1'b0);
    wr(4'h5, 8'h00);
    wr(4'h5, 8'h01);
    pwr_cycle();
    wait_run(1, 1'b1, 200);
    wr(4'h5, 8'h00);
    wait_run(1, 1'b0, 3);
    wr(4'h5, 8'h01);
    pwr_cycle();
    wr(4'h9, 8'h02);
    wait_run(1, 1'b1, 200);
    repeat (HR) @(negedge clk);
    check("prescan_run", prescan_run, 1'b1);
    wait_run(1, 1'b0, 3 * HR);
    $display("test prescan done");
    complete_run();
  end
endmodule
